// >>> src/lcf_pkg.sv
// Purpose: Constants shared by the LED channel fault manager
// Assumes: 20 MHz system clock
// Notes:   Register offsets are byte addresses on classic Wishbone
package lcf_pkg;
    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned FAULT_TIME_US   = 1000;
    localparam int unsigned SOFT_TIME_US    = 500;
    localparam int unsigned FAULT_CYCLES    = FAULT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SOFT_CYCLES     = SOFT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W           = 24;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_MASK    = 4'h4;
    localparam logic [3:0] ADDR_CONFIG  = 4'h8;
    localparam logic [3:0] ADDR_IRQ_EN  = 4'hC;

    // ************************************************************
    // Status and config bit positions for the single channel served here
    // ************************************************************
    localparam int unsigned BIT_OV      = 0;
    localparam int unsigned BIT_OPEN    = 1;
    localparam int unsigned BIT_SHORT   = 2;
    localparam int unsigned BIT_OC      = 3;
    localparam int unsigned CFG_LATCH   = 7;
    localparam int unsigned CFG_SERIAL  = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [3:0] MASK_RESET   = 4'hF;
    localparam logic [7:0] CONFIG_RESET = 8'h01;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;

    typedef enum logic [4:0] {
        ST_OFF   = 5'b0_0001,
        ST_SOFT  = 5'b0_0010,
        ST_RUN   = 5'b0_0100,
        ST_WAIT  = 5'b0_1000,
        ST_LATCH = 5'b1_0000
    } lcf_state_t;
endpackage

// >>> src/lcf_channel.sv
// Purpose: Fault supervision and response for one LED driver channel
// Assumes: Comparator decisions arrive as plain logic levels
// Notes:   Status clears by writing one; set wins over clear
//
// How it works
// - Enable below run threshold stops switching and turns the dimming gate off.
// - Enable below shutdown threshold disables all functions; bias, gate and switching go off but status and alert stay live.
// - Overvoltage halts switching, gate off, sets status bit, raises notification.
// - Feedback high with near-zero sense difference flags open string.
// - Feedback below short level after start-up flags shorted string.
// - Sense difference above overcurrent level sets status and notification together; in non-serial mode notification comes a cycle before status.
// - Short or overcurrent stops switching and turns the dimming gate off.
// - Hiccup response unless latch-off is selected.
// - Hiccup waits for timer expiry and fault gone before restarting.
// - Restart drives gate high and switches after soft-start.
// - Serial mode holds notification until clear; otherwise it follows the fault and also stays on through the hiccup wait.
// - Latch-off config stops switching after a fault until an enable low-to-high transition.
// - Only an enable low-to-high transition leaves latch-off.
// - Status bits stay latched until the host clears them.
// - Notification only for mask-enabled bits, except during the hiccup wait in non-serial mode; mask resets to all enabled.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lcf_channel #(
    parameter int unsigned FAULT_CYCLES = lcf_pkg::FAULT_CYCLES,
    parameter int unsigned SOFT_CYCLES  = lcf_pkg::SOFT_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESET_N_I,
    // Comparator decisions
    input  wire logic        EN_RUN_I,
    input  wire logic        EN_ON_I,
    input  wire logic        FB_OV_I,
    input  wire logic        FB_OPEN_I,
    input  wire logic        FB_SHORT_I,
    input  wire logic        SENSE_LOW_I,
    input  wire logic        SENSE_OC_I,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic [3:0]  WB_SEL_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // Power stage and notification
    output logic             SWITCH_EN_O,
    output logic             GATE_ON_O,
    output logic             BIAS_ON_O,
    output logic             ALERT_N_O,
    output logic             IRQ_O
);
    // ************************************************************
    // Synchronisers
    // ************************************************************
    localparam int unsigned NS = 7;
    logic [NS-1:0] raw_w;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    assign raw_w = {EN_RUN_I, EN_ON_I, FB_OV_I, FB_OPEN_I, FB_SHORT_I, SENSE_LOW_I, SENSE_OC_I};

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= raw_w;
            s2_q <= s1_q;
        end
    end

    logic en_run_w, en_on_w, ov_w, open_w, short_w, oc_w, en_run_prev_q;
    assign en_run_w = s2_q[6];
    assign en_on_w  = s2_q[5];
    assign ov_w     = s2_q[4];
    assign open_w   = s2_q[3] & s2_q[1];
    assign oc_w     = s2_q[0];

    // ************************************************************
    // Registers and bus
    // ************************************************************
    logic [3:0] status_q;
    logic [3:0] mask_q;
    logic [7:0] config_q;
    logic [3:0] irq_en_q;
    logic       ack_q;
    logic [31:0] rdata_q;
    logic       started_q;
    lcf_pkg::lcf_state_t state_q;

    logic req_w, wr_w, wr_st_w, wr_mk_w, wr_cf_w, wr_ie_w, hit_w;
    assign req_w   = WB_CYC_I & WB_STB_I & ~ack_q;
    assign wr_w    = req_w & WB_WE_I & WB_SEL_I[0];
    assign wr_st_w = wr_w & (WB_ADR_I == lcf_pkg::ADDR_STATUS);
    assign wr_mk_w = wr_w & (WB_ADR_I == lcf_pkg::ADDR_MASK);
    assign wr_cf_w = wr_w & (WB_ADR_I == lcf_pkg::ADDR_CONFIG);
    assign wr_ie_w = wr_w & (WB_ADR_I == lcf_pkg::ADDR_IRQ_EN);
    assign hit_w   = (WB_ADR_I == lcf_pkg::ADDR_STATUS) | (WB_ADR_I == lcf_pkg::ADDR_MASK)
                   | (WB_ADR_I == lcf_pkg::ADDR_CONFIG) | (WB_ADR_I == lcf_pkg::ADDR_IRQ_EN);

    logic [31:0] rsel_w;
    assign rsel_w = !hit_w ? 32'h0000_0000 :
                    (WB_ADR_I == lcf_pkg::ADDR_STATUS) ? {28'h000_0000, status_q} :
                    (WB_ADR_I == lcf_pkg::ADDR_MASK)   ? {28'h000_0000, mask_q} :
                    (WB_ADR_I == lcf_pkg::ADDR_CONFIG) ? {24'h00_0000, config_q} :
                    {23'h00_0000, state_q, irq_en_q};

    // Fault events
    assign short_w = started_q & s2_q[2];
    logic [3:0] ev_w;
    assign ev_w = {oc_w, short_w, open_w, ov_w};
    logic [3:0] status_d;
    logic [3:0] clr_w;
    assign clr_w = wr_st_w ? WB_DAT_I[3:0] : 4'h0;

    // ************************************************************
    // Status bits, one per fault kind
    // ************************************************************
    for (genvar i = 0; i < 4; i++)
    begin : g_status
        assign status_d[i] = ev_w[i] | (status_q[i] & ~clr_w[i]);
        chk_bit_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
            status_q[i] && !clr_w[i] |=> status_q[i])
            else $error("status bit dropped");
        chk_bit_set: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
            ev_w[i] |=> status_q[i])
            else $error("fault not recorded");
        chk_bit_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
            clr_w[i] && !ev_w[i] |=> !status_q[i])
            else $error("status bit not cleared");
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            status_q <= 4'h0;
            mask_q   <= lcf_pkg::MASK_RESET;
            config_q <= lcf_pkg::CONFIG_RESET;
            irq_en_q <= lcf_pkg::IRQ_EN_RESET;
            ack_q    <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end
        else
        begin
            status_q <= status_d;
            ack_q    <= req_w;
            if (req_w)
                rdata_q <= rsel_w;
            if (wr_mk_w)
                mask_q <= WB_DAT_I[3:0];
            if (wr_cf_w)
                config_q <= WB_DAT_I[7:0];
            if (wr_ie_w)
                irq_en_q <= WB_DAT_I[3:0];
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;

    chk_ack_follow: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        req_w |=> WB_ACK_O)
        else $error("request not acknowledged");
    chk_ack_pulse: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge held");
    chk_unmapped_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        req_w && !hit_w |=> WB_DAT_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_mask_write: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        wr_mk_w |=> mask_q == $past(WB_DAT_I[3:0]))
        else $error("mask write lost");
    chk_cfg_write: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        wr_cf_w |=> config_q == $past(WB_DAT_I[7:0]))
        else $error("config write lost");

    // ************************************************************
    // Response state machine
    // ************************************************************
    logic [23:0] cnt_q;
    logic        hard_w, serial_w, latch_w;
    assign hard_w   = short_w | oc_w;
    assign serial_w = config_q[lcf_pkg::CFG_SERIAL];
    assign latch_w  = config_q[lcf_pkg::CFG_LATCH];

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state_q       <= lcf_pkg::ST_OFF;
            cnt_q         <= 24'h00_0000;
            started_q     <= 1'b0;
            en_run_prev_q <= 1'b0;
        end
        else
        begin
            en_run_prev_q <= en_run_w;
            unique case (state_q)
                lcf_pkg::ST_OFF:
                    if (en_run_w & en_on_w)
                    begin
                        state_q <= lcf_pkg::ST_SOFT;
                        cnt_q   <= 24'h00_0000;
                    end
                lcf_pkg::ST_SOFT, lcf_pkg::ST_RUN:
                    if (!en_run_w | !en_on_w)
                    begin
                        state_q   <= lcf_pkg::ST_OFF;
                        started_q <= 1'b0;
                    end
                    else if (hard_w)
                    begin
                        state_q <= latch_w ? lcf_pkg::ST_LATCH : lcf_pkg::ST_WAIT;
                        cnt_q   <= 24'h00_0000;
                    end
                    else if (state_q == lcf_pkg::ST_SOFT)
                    begin
                        if (cnt_q >= 24'(SOFT_CYCLES - 1))
                        begin
                            state_q   <= lcf_pkg::ST_RUN;
                            started_q <= 1'b1;
                        end
                        else
                            cnt_q <= cnt_q + 24'h00_0001;
                    end
                lcf_pkg::ST_WAIT:
                    if (!en_run_w | !en_on_w)
                    begin
                        state_q   <= lcf_pkg::ST_OFF;
                        started_q <= 1'b0;
                    end
                    else if (cnt_q >= 24'(FAULT_CYCLES - 1))
                    begin
                        if (!(s2_q[2] | oc_w))
                        begin
                            state_q   <= lcf_pkg::ST_SOFT;
                            started_q <= 1'b0;
                            cnt_q     <= 24'h00_0000;
                        end
                    end
                    else
                        cnt_q <= cnt_q + 24'h00_0001;
                lcf_pkg::ST_LATCH:
                    if (en_run_w & !en_run_prev_q & en_on_w)
                    begin
                        state_q   <= lcf_pkg::ST_SOFT;
                        started_q <= 1'b0;
                        cnt_q     <= 24'h00_0000;
                    end
            endcase
        end
    end

    // ************************************************************
    // Response checks
    // ************************************************************
    logic en_ok_w;
    logic active_w;
    assign en_ok_w  = en_run_w & en_on_w;
    assign active_w = (state_q == lcf_pkg::ST_SOFT) | (state_q == lcf_pkg::ST_RUN);

    chk_hiccup_sel: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        active_w && en_ok_w && hard_w && !latch_w |=> state_q == lcf_pkg::ST_WAIT)
        else $error("no hiccup on fault");
    chk_latch_sel: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        active_w && en_ok_w && hard_w && latch_w |=> state_q == lcf_pkg::ST_LATCH)
        else $error("no latch-off on fault");
    chk_wait_timer: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        state_q == lcf_pkg::ST_WAIT && en_ok_w && cnt_q < 24'(FAULT_CYCLES - 1) |=> state_q == lcf_pkg::ST_WAIT)
        else $error("restart before timer expiry");
    chk_wait_fault: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        state_q == lcf_pkg::ST_WAIT && en_ok_w && (s2_q[2] || oc_w) |=> state_q == lcf_pkg::ST_WAIT)
        else $error("restart with fault present");
    chk_latch_exit: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        state_q == lcf_pkg::ST_LATCH && !(en_run_w && !en_run_prev_q) |=> state_q == lcf_pkg::ST_LATCH)
        else $error("latch left without enable rise");
    chk_soft_length: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        $rose(state_q == lcf_pkg::ST_RUN) |-> $past(cnt_q) >= 24'(SOFT_CYCLES - 1))
        else $error("soft start cut short");
    chk_early_short: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        state_q == lcf_pkg::ST_SOFT |-> !short_w)
        else $error("short flagged during start-up");

    // ************************************************************
    // Outputs
    // ************************************************************
    logic alert_w, ov_stop_w;
    assign ov_stop_w   = ov_w;
    assign SWITCH_EN_O = (state_q == lcf_pkg::ST_RUN) & ~ov_stop_w & ~hard_w;
    assign GATE_ON_O   = ((state_q == lcf_pkg::ST_RUN) | (state_q == lcf_pkg::ST_SOFT)) & ~ov_stop_w & ~hard_w;
    assign BIAS_ON_O   = en_on_w;
    assign alert_w     = serial_w ? |(status_q & mask_q)
                                  : |(ev_w & mask_q) | (state_q == lcf_pkg::ST_WAIT);
    assign ALERT_N_O   = ~alert_w;
    assign IRQ_O       = |(status_q & irq_en_q);

    // ************************************************************
    // Checks
    // ************************************************************
    chk_status_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        status_q[0] & ~(wr_st_w & WB_DAT_I[0]) |=> status_q[0]) else $error("status dropped");
    chk_ov_stops: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        ov_w |-> !SWITCH_EN_O && !GATE_ON_O) else $error("switching on overvoltage");
    chk_oc_flag: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        oc_w |=> status_q[3]) else $error("overcurrent not flagged");
    chk_latch_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        state_q == lcf_pkg::ST_LATCH && !en_run_w |=> state_q == lcf_pkg::ST_LATCH) else $error("left latch");
    chk_hard_stop: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        hard_w |-> !SWITCH_EN_O) else $error("switching on short");
    chk_uv_stop: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !en_run_w |=> !SWITCH_EN_O) else $error("switching in undervoltage");
    chk_mask_alert: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        serial_w && (status_q & mask_q) == 4'h0 |-> ALERT_N_O) else $error("masked alert");
    chk_soft_first: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        $rose(state_q == lcf_pkg::ST_RUN) |-> $past(state_q) == lcf_pkg::ST_SOFT) else $error("no soft start");

    chk_uv_gate: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !en_run_w |=> !GATE_ON_O)
        else $error("gate on in undervoltage");
    chk_shutdown_bias: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !en_on_w |-> !BIAS_ON_O)
        else $error("bias on in shutdown");
    chk_shutdown_off: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !en_on_w |=> !SWITCH_EN_O && !GATE_ON_O)
        else $error("power stage on in shutdown");
    chk_soft_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        state_q == lcf_pkg::ST_SOFT |-> !SWITCH_EN_O)
        else $error("switching during soft start");
    chk_serial_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        serial_w && (status_q & mask_q) != 4'h0 |-> !ALERT_N_O)
        else $error("serial alert released");
    chk_live_alert: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        !serial_w && (ev_w & mask_q) != 4'h0 |-> !ALERT_N_O)
        else $error("live fault not reported");
    chk_irq_mask: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (status_q & irq_en_q) == 4'h0 |-> !IRQ_O)
        else $error("interrupt without enabled status");
endmodule
`default_nettype wire

// >>> tb/lcf_string_model.sv
// Purpose: Behavioural LED string, disconnect switch and sense network
// Assumes: The bench selects which fault the string shows
// Notes:   Codes 0 none, 1 overvoltage, 2 open, 3 shorted, 4 overcurrent
`timescale 1ns/1ps
`default_nettype none
module lcf_string_model (
    // Control
    input  wire logic [2:0] fault_sel_i,
    input  wire logic       gate_on_i,
    // Comparator levels
    output logic            fb_ov_o,
    output logic            fb_open_o,
    output logic            fb_short_o,
    output logic            sense_low_o,
    output logic            sense_oc_o
);
    assign fb_ov_o     = (fault_sel_i == 3'h1);
    assign fb_open_o   = (fault_sel_i == 3'h2);
    assign fb_short_o  = (fault_sel_i == 3'h3);
    assign sense_oc_o  = (fault_sel_i == 3'h4);
    // No current flows while the string is open or disconnected
    assign sense_low_o = (fault_sel_i == 3'h2) || !gate_on_i;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the channel fault manager
// Assumes: Fault timer and soft-start counts shortened by parameters
// Notes:   Expected status is kept in an integer model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int FC = 20;
    localparam int SC = 10;
    localparam int RW = FC + SC + 15;
    logic        clk;
    logic        rst_n     = 1'b0;
    logic        en_run    = 1'b1;
    logic        en_on     = 1'b1;
    logic [2:0]  fault_sel = 3'h0;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic        we        = 1'b0;
    logic [3:0]  adr       = 4'h0;
    logic [31:0] wdat      = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack, sw_en, gate_on, bias_on, alert_n, irq;
    logic        ov, open_f, short_f, low, oc;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          seed = 32'h0000_385F;
    int          exp_status = 0;
    int          m;
    int          k;
    // ************************************************************
    // Clock, partner and design
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    lcf_string_model lcf_string_model_inst (.fault_sel_i(fault_sel), .gate_on_i(gate_on), .fb_ov_o(ov),
        .fb_open_o(open_f), .fb_short_o(short_f), .sense_low_o(low), .sense_oc_o(oc));
    lcf_channel #(.FAULT_CYCLES(FC), .SOFT_CYCLES(SC)) lcf_channel_inst (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
        .EN_RUN_I(en_run), .EN_ON_I(en_on), .FB_OV_I(ov), .FB_OPEN_I(open_f), .FB_SHORT_I(short_f),
        .SENSE_LOW_I(low), .SENSE_OC_I(oc), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_DAT_I(wdat), .WB_SEL_I(4'hF), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SWITCH_EN_O(sw_en),
        .GATE_ON_O(gate_on), .BIAS_ON_O(bias_on), .ALERT_N_O(alert_n), .IRQ_O(irq));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic wrap_up();
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_c(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd & msk);
    endtask
    task automatic inject(input int f);
        @(posedge clk);
        fault_sel <= f[2:0];
        wait_c(6);
        fault_sel <= 3'h0;
        exp_status = exp_status | (1 << (f - 1));
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        wait_c(2);
        rst_n <= 1'b1;
        wait_c(SC + 10);
        rchk(lcf_pkg::ADDR_MASK, 32'hFFFF_FFFF, 32'h0000_000F, "mask");
        rchk(lcf_pkg::ADDR_CONFIG, 32'hFFFF_FFFF, 32'h0000_0001, "config");
        rchk(lcf_pkg::ADDR_IRQ_EN, 32'h0000_000F, 32'h0000_0000, "irq_en");
        rchk(lcf_pkg::ADDR_STATUS, 32'hFFFF_FFFF, exp_status, "status");
        rchk(4'h2, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
        chk("bias", 1, bias_on);
        chk("switch", 1, sw_en);
        for (k = 1; k <= 4; k++)
        begin
            inject(k);
            chk("alert", 0, alert_n);
            chk("gate", (k == 2), gate_on);
            chk("switch", (k == 2), sw_en);
            wait_c(4);
            if (k > 2)
                chk("switch", 0, sw_en);
            wait_c(RW);
            if (k != 1)
                chk("switch", 1, sw_en);
            chk("alert", 0, alert_n);
            rchk(lcf_pkg::ADDR_STATUS, 32'hFFFF_FFFF, exp_status, "status");
            wb(1'b1, lcf_pkg::ADDR_STATUS, 1 << (k - 1));
            exp_status = 0;
            wait_c(2);
            chk("alert", 1, alert_n);
        end
        wb(1'b1, lcf_pkg::ADDR_CONFIG, 32'h0000_0000);
        inject(4);
        chk("alert", 0, alert_n);
        wait_c(RW);
        chk("alert", 1, alert_n);
        fault_sel <= 3'h4;
        wait_c(FC + 10);
        chk("switch", 0, sw_en);
        chk("alert", 0, alert_n);
        fault_sel <= 3'h0;
        wait_c(RW);
        chk("switch", 1, sw_en);
        rchk(lcf_pkg::ADDR_STATUS, 32'hFFFF_FFFF, exp_status, "status");
        wb(1'b1, lcf_pkg::ADDR_STATUS, 32'h0000_000F);
        exp_status = 0;
        wb(1'b1, lcf_pkg::ADDR_CONFIG, 32'h0000_0001);
        for (k = 0; k < 3; k++)
        begin
            m = $random(seed);
            wb(1'b1, lcf_pkg::ADDR_MASK, m);
            inject(1);
            chk("alert", !m[0], alert_n);
            wait_c(RW);
            wb(1'b1, lcf_pkg::ADDR_STATUS, 32'h0000_0001);
            exp_status = 0;
        end
        wb(1'b1, lcf_pkg::ADDR_MASK, 32'h0000_000F);
        wb(1'b1, lcf_pkg::ADDR_IRQ_EN, 32'h0000_0008);
        inject(2);
        chk("irq", 0, irq);
        inject(4);
        chk("irq", 1, irq);
        wait_c(RW);
        wb(1'b1, lcf_pkg::ADDR_STATUS, 32'h0000_000F);
        exp_status = 0;
        wait_c(2);
        chk("irq", 0, irq);
        wb(1'b1, lcf_pkg::ADDR_CONFIG, 32'h0000_0081);
        inject(4);
        wait_c(RW);
        chk("switch", 0, sw_en);
        chk("gate", 0, gate_on);
        en_run <= 1'b0;
        wait_c(5);
        chk("switch", 0, sw_en);
        chk("gate", 0, gate_on);
        chk("bias", 1, bias_on);
        en_run <= 1'b1;
        wait_c(SC + 15);
        chk("switch", 1, sw_en);
        en_run <= 1'b0;
        en_on  <= 1'b0;
        wait_c(5);
        chk("bias", 0, bias_on);
        chk("switch", 0, sw_en);
        wrap_up();
    end
endmodule
`default_nettype wire
